// file: include/sbc_pkg.sv
// Package with constants, register map and states of the link self-test control.
// Operation
// RULE_01 - Pin high or control bit starts test
// RULE_02 - Send back-channel writes configuring remote serializer
// RULE_03 - Remote serializer sends continuous full-speed pattern
// RULE_04 - Detect and check pattern on every port
// RULE_05 - Remote serializer counts back-channel CRC errors
// RULE_06 - Lock, pass, line monitor stay working
// RULE_07 - Per-port error counter at offset 0x57
// RULE_08 - Pin mode sends general pin levels
// RULE_09 - Clock code 00 external, else internal
// RULE_10 - Sample general pins on pin rising edge
// RULE_11 - Pass pin pulses low per error
// RULE_12 - Report 0xFF on no lock, cap 0xFE
// RULE_13 - Control bits 7:6 gate outputs
// RULE_14 - Enabled outputs idle LP-11 unless pattern generator
// RULE_15 - Register mode sends clock-source field
// RULE_16 - Clock field captured once at start
// RULE_17 - Software avoids code 11 with parallel serializers
// RULE_18 - Software also routes lock status to pins
// RULE_19 - Registers reachable from local and control channel
// RULE_20 - Counter cleared at start, increments, saturates
package sbc_pkg;
  localparam int NUM_PORTS = 2;
  // Local register offsets.
  localparam logic [7:0] ADDR_PORT_PAGE = 8'h4c;
  localparam logic [7:0] ADDR_ERR_COUNT = 8'h57;
  localparam logic [7:0] ADDR_CONTROL = 8'hb3;
  // Port page register fields.
  localparam int PAGE_RD_LSB = 4;
  localparam logic [7:0] PAGE_MASK = 8'h33;
  localparam logic [7:0] PAGE_RESET = 8'h03;
  // Control register fields.
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_CLK_LSB = 1;
  localparam int CTL_GATE_LSB = 6;
  localparam logic [7:0] CTL_MASK = 8'hc7;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [1:0] GATE_OUT_OFF = 2'h0;
  localparam logic [1:0] GATE_OUT_ON = 2'h2;
  localparam logic [1:0] CLK_EXTERNAL = 2'h0;
  // Remote serializer register that takes the self-test setup.
  localparam logic [7:0] SER_ADDR_BIST = 8'h14;
  localparam int SER_EN_BIT = 0;
  localparam int SER_CLK_LSB = 1;
  // Error counter values.
  localparam logic [7:0] ERR_NO_LOCK = 8'hff;
  localparam logic [7:0] ERR_MAX = 8'hfe;
  localparam logic [7:0] ERR_ZERO = 8'h00;
  // Correct bits in a row before the pattern counts as found.
  localparam logic [4:0] PAT_FOUND_BITS = 5'h10;
  // Pattern generator taps, seven-bit sequence.
  localparam int PRBS_TAP_A = 6;
  localparam int PRBS_TAP_B = 5;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_START_WR = 4'b0010,
    ST_RUN = 4'b0100,
    ST_STOP_WR = 4'b1000
  } sbc_state_t;
endpackage : sbc_pkg

// file: src/sbc_top.sv
// Deserializer-side control of the link built-in self test.
`timescale 1ns/1ps
module sbc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  // Self-test pin and two general pins, asynchronous.
  input wire logic link_selftest_pin_i,
  input wire logic [1:0] gpio_level_i,
  // Local register port.
  input wire logic host_req_i,
  input wire logic host_we_i,
  input wire logic [7:0] host_addr_i,
  input wire logic [7:0] host_wdata_i,
  output logic host_ack_o,
  output logic [7:0] host_rdata_o,
  // Register port fed from the link control channel.
  input wire logic cc_req_i,
  input wire logic cc_we_i,
  input wire logic [7:0] cc_addr_i,
  input wire logic [7:0] cc_wdata_i,
  output logic cc_ack_o,
  output logic [7:0] cc_rdata_o,
  // Back-channel write request to the remote serializer.
  output logic bc_wr_valid_o,
  output logic [7:0] bc_wr_addr_o,
  output logic [7:0] bc_wr_data_o,
  input wire logic bc_wr_ready_i,
  // Receive ports, from the link receiver on this clock.
  input wire logic [1:0] rx_lock_i,
  input wire logic [1:0] rx_bit_valid_i,
  input wire logic [1:0] rx_bit_i,
  input wire logic line_monitor_i,
  input wire logic patgen_on_i,
  // Status and gating outputs.
  output logic [1:0] lock_o,
  output logic [1:0] pass_o,
  output logic line_monitor_out_o,
  output logic selftest_active_o,
  output logic out_enable_o,
  output logic csi_lp11_o
);

  localparam int NP = sbc_pkg::NUM_PORTS;

  logic pin_meta;
  logic pin_sync;
  logic pin_prev;
  logic [1:0] gpio_meta;
  logic [1:0] gpio_sync;
  logic pin_rise;
  logic [7:0] port_page;
  logic [7:0] control;
  logic ctl_en;
  logic [1:0] clk_sel;
  logic pin_mode;
  logic start_req;
  logic stop_req;
  logic test_start;
  sbc_pkg::sbc_state_t state;
  logic run;
  logic [7:0] err_count [NP];
  logic [NP-1:0] lock_seen;
  logic [NP-1:0] lock_lost;
  logic [7:0] err_report [NP];
  logic sel_host;
  logic acc_req;
  logic acc_we;
  logic [7:0] acc_addr;
  logic [7:0] acc_wdata;
  logic [7:0] acc_rdata;
  logic [0:0] rd_port;

  // Two-stage synchroniser for the self-test pin, plus its previous level.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= link_selftest_pin_i;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Two-stage synchroniser for the general pins that carry the clock code.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gpio_meta <= 2'h0;
      gpio_sync <= 2'h0;
    end else begin
      gpio_meta <= gpio_level_i;
      gpio_sync <= gpio_meta;
    end
  end

  // Rising edge of the synchronised self-test pin; low idle matches reset.
  assign pin_rise = pin_sync & ~pin_prev;

  // Both register ports share one register file; the local port wins a tie.
  assign sel_host = host_req_i; // RULE_19
  assign acc_req = host_req_i | cc_req_i; // RULE_19
  assign acc_we = sel_host ? host_we_i : cc_we_i;
  assign acc_addr = sel_host ? host_addr_i : cc_addr_i;
  assign acc_wdata = sel_host ? host_wdata_i : cc_wdata_i;
  assign rd_port = port_page[sbc_pkg::PAGE_RD_LSB +: 1];

  // Port page register selects which port's error counter a read reaches.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_page <= sbc_pkg::PAGE_RESET;
    end else if (acc_req && acc_we &&
                 acc_addr == sbc_pkg::ADDR_PORT_PAGE) begin
      port_page <= acc_wdata & sbc_pkg::PAGE_MASK;
    end
  end

  // Control register; software setting the enable bit starts a test.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control <= sbc_pkg::CTL_RESET;
    end else if (acc_req && acc_we &&
                 acc_addr == sbc_pkg::ADDR_CONTROL) begin
      control <= acc_wdata & sbc_pkg::CTL_MASK; // RULE_01
    end
  end

  assign ctl_en = control[sbc_pkg::CTL_EN_BIT];

  // Read data mux over the mapped registers; all else reads zero.
  always_comb begin
    acc_rdata = 8'h00;
    unique case (acc_addr)
      sbc_pkg::ADDR_PORT_PAGE: acc_rdata = port_page;
      sbc_pkg::ADDR_CONTROL: acc_rdata = control;
      sbc_pkg::ADDR_ERR_COUNT: acc_rdata = err_report[rd_port]; // RULE_07
      default: acc_rdata = 8'h00;
    endcase
  end

  // Local register port answers one cycle after the request.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_ack_o <= 1'b0;
      host_rdata_o <= 8'h00;
    end else begin
      host_ack_o <= host_req_i;
      if (host_req_i && !host_we_i) begin
        host_rdata_o <= acc_rdata;
      end
    end
  end

  // Control-channel port answers likewise, unless the local port won.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cc_ack_o <= 1'b0;
      cc_rdata_o <= 8'h00;
    end else begin
      cc_ack_o <= cc_req_i & ~host_req_i;
      if (cc_req_i && !host_req_i && !cc_we_i) begin
        cc_rdata_o <= acc_rdata;
      end
    end
  end

  // A start comes from the pin edge or the enable bit while idle.
  assign start_req = pin_rise | ctl_en; // RULE_01
  assign stop_req = pin_mode ? ~pin_sync : ~ctl_en;
  assign test_start = (state == sbc_pkg::ST_IDLE) && start_req;
  assign run = (state == sbc_pkg::ST_RUN);

  // Sequencer: set up the serializer, run, then release it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= sbc_pkg::ST_IDLE;
    end else begin
      unique case (state)
        sbc_pkg::ST_IDLE: begin
          if (start_req) begin
            state <= sbc_pkg::ST_START_WR; // RULE_02
          end
        end
        sbc_pkg::ST_START_WR: begin
          if (bc_wr_ready_i) begin
            state <= sbc_pkg::ST_RUN;
          end
        end
        sbc_pkg::ST_RUN: begin
          if (stop_req) begin
            state <= sbc_pkg::ST_STOP_WR;
          end
        end
        sbc_pkg::ST_STOP_WR: begin
          if (bc_wr_ready_i) begin
            state <= sbc_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Mode and clock code are caught once, at the start of the test.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_mode <= 1'b0;
      clk_sel <= sbc_pkg::CLK_EXTERNAL;
    end else if (test_start) begin
      pin_mode <= pin_rise;
      if (pin_rise) begin
        clk_sel <= gpio_sync; // RULE_08 RULE_10
      end else begin
        clk_sel <= control[sbc_pkg::CTL_CLK_LSB +: 2]; // RULE_15 RULE_16
      end
    end
  end

  // Back-channel write of the serializer self-test register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bc_wr_valid_o <= 1'b0;
      bc_wr_addr_o <= 8'h00;
      bc_wr_data_o <= 8'h00;
    end else if (bc_wr_valid_o && bc_wr_ready_i) begin
      bc_wr_valid_o <= 1'b0;
    end else if (state == sbc_pkg::ST_START_WR && !bc_wr_valid_o) begin
      bc_wr_valid_o <= 1'b1; // RULE_02
      bc_wr_addr_o <= sbc_pkg::SER_ADDR_BIST;
      bc_wr_data_o <= 8'h00;
      bc_wr_data_o[sbc_pkg::SER_CLK_LSB +: 2] <= clk_sel; // RULE_09
      bc_wr_data_o[sbc_pkg::SER_EN_BIT] <= 1'b1;
    end else if (state == sbc_pkg::ST_STOP_WR && !bc_wr_valid_o) begin
      bc_wr_valid_o <= 1'b1;
      bc_wr_addr_o <= sbc_pkg::SER_ADDR_BIST;
      bc_wr_data_o <= 8'h00;
    end
  end

  // Per-port pattern checker, error counter and pass pulse.
  for (genvar p = 0; p < NP; p++) begin : g_port
    logic [6:0] prbs;
    logic [4:0] good_run;
    logic found;
    logic bit_ok;
    logic bit_err;

    assign bit_ok = rx_bit_i[p] == (prbs[sbc_pkg::PRBS_TAP_A] ^
                                    prbs[sbc_pkg::PRBS_TAP_B]);
    assign bit_err = run && found && rx_lock_i[p] && rx_bit_valid_i[p] &&
                     !bit_ok; // RULE_04

    // Self-seeding checker; finds the pattern after a run of good bits.
    always_ff @(posedge clk_i) begin
      if (rst_i || test_start || !rx_lock_i[p]) begin
        prbs <= 7'h00;
        good_run <= 5'h00;
        found <= 1'b0;
      end else if (rx_bit_valid_i[p]) begin
        prbs <= {prbs[5:0], rx_bit_i[p]};
        if (!found) begin
          if (!bit_ok) begin
            good_run <= 5'h00;
          end else if (good_run == sbc_pkg::PAT_FOUND_BITS - 5'h01) begin
            found <= 1'b1; // RULE_04
          end else begin
            good_run <= good_run + 5'h01;
          end
        end
      end
    end

    // Counter cleared at start, counts errors, stops at the maximum.
    always_ff @(posedge clk_i) begin
      if (rst_i || test_start) begin
        err_count[p] <= sbc_pkg::ERR_ZERO; // RULE_20
      end else if (bit_err && err_count[p] != sbc_pkg::ERR_MAX) begin
        err_count[p] <= err_count[p] + 8'h01; // RULE_20 RULE_12
      end
    end

    // Lock history of the current test.
    always_ff @(posedge clk_i) begin
      if (rst_i || test_start) begin
        lock_seen[p] <= 1'b0;
        lock_lost[p] <= 1'b0;
      end else if (run) begin
        if (rx_lock_i[p]) begin
          lock_seen[p] <= 1'b1;
        end else if (lock_seen[p]) begin
          lock_lost[p] <= 1'b1; // RULE_12
        end
      end
    end

    assign err_report[p] = (!lock_seen[p] || lock_lost[p]) ?
                           sbc_pkg::ERR_NO_LOCK : err_count[p]; // RULE_12

    // Pass indication drops for one cycle on each error.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pass_o[p] <= 1'b1;
      end else begin
        pass_o[p] <= ~bit_err; // RULE_11 RULE_06
      end
    end
  end

  // Lock outputs stay live in every state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_o <= 2'h0;
    end else begin
      lock_o <= rx_lock_i; // RULE_06
    end
  end

  // Line monitor output stays live in every state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_monitor_out_o <= 1'b0;
    end else begin
      line_monitor_out_o <= line_monitor_i; // RULE_06
    end
  end

  // Test-active flag, registered; rises on the edge that ends the start cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      selftest_active_o <= 1'b0;
    end else begin
      selftest_active_o <= (state != sbc_pkg::ST_IDLE) || test_start;
    end
  end

  // Output gating while a test is in progress.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_enable_o <= 1'b1;
      csi_lp11_o <= 1'b0;
    end else if (state != sbc_pkg::ST_IDLE || test_start) begin
      out_enable_o <= control[sbc_pkg::CTL_GATE_LSB +: 2] ==
                      sbc_pkg::GATE_OUT_ON; // RULE_13
      csi_lp11_o <= ~patgen_on_i; // RULE_14
    end else begin
      out_enable_o <= 1'b1;
      csi_lp11_o <= 1'b0;
    end
  end

endmodule : sbc_top

// file: dv/sbc_top_asserts.sv
// Concurrent checks on the ports of the link self-test control.
`timescale 1ns/1ps
module sbc_top_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic host_req_i,
  input wire logic host_ack_o,
  input wire logic cc_req_i,
  input wire logic cc_ack_o,
  input wire logic bc_wr_valid_o,
  input wire logic [7:0] bc_wr_addr_o,
  input wire logic [7:0] bc_wr_data_o,
  input wire logic bc_wr_ready_i,
  input wire logic [1:0] rx_lock_i,
  input wire logic line_monitor_i,
  input wire logic patgen_on_i,
  input wire logic [1:0] lock_o,
  input wire logic [1:0] pass_o,
  input wire logic line_monitor_out_o,
  input wire logic selftest_active_o,
  input wire logic out_enable_o,
  input wire logic csi_lp11_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Both register ports answer exactly one cycle after a taken request.
  a_host_ack_one: assert property (host_req_i |=> host_ack_o)
    else $error("host request not acknowledged");
  a_cc_ack_one: assert property (cc_req_i && !host_req_i |=> cc_ack_o)
    else $error("control channel request not acknowledged");
  // A serializer write holds until accepted and always targets 0x14.
  a_bc_write_hold: assert property (bc_wr_valid_o && !bc_wr_ready_i |=>
    bc_wr_valid_o && $stable(bc_wr_addr_o) && $stable(bc_wr_data_o))
    else $error("back channel write changed before acceptance");
  a_bc_write_addr: assert property (bc_wr_valid_o |->
    bc_wr_addr_o == 8'h14)
    else $error("back channel write to wrong register");
  a_start_sends_write: assert property ($rose(selftest_active_o) |->
    ##[1:3] bc_wr_valid_o)
    else $error("no serializer write after test start");
  // Status outputs keep following their inputs during the test.
  a_status_follow: assert property (!$past(rst_i) |->
    lock_o == $past(rx_lock_i) &&
    line_monitor_out_o == $past(line_monitor_i))
    else $error("lock or line monitor output not following input");
  a_outputs_idle_on: assert property (!selftest_active_o &&
    !$past(selftest_active_o) |-> out_enable_o)
    else $error("outputs gated outside the test");
  a_lp11_idle_state: assert property (selftest_active_o &&
    $past(selftest_active_o) |-> csi_lp11_o == !$past(patgen_on_i))
    else $error("transmitter idle state wrong during test");
  a_pass_only_test: assert property (pass_o != 2'h3 |->
    $past(selftest_active_o))
    else $error("pass indication low outside the test");
  c_test_start: cover property ($rose(selftest_active_o));
  c_error_seen: cover property (!pass_o[0]);
  c_write_stall: cover property (bc_wr_valid_o && !bc_wr_ready_i);
endmodule : sbc_top_asserts
bind sbc_top sbc_top_asserts i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .host_req_i(host_req_i), .host_ack_o(host_ack_o), .cc_req_i(cc_req_i),
  .cc_ack_o(cc_ack_o), .bc_wr_valid_o(bc_wr_valid_o),
  .bc_wr_addr_o(bc_wr_addr_o), .bc_wr_data_o(bc_wr_data_o),
  .bc_wr_ready_i(bc_wr_ready_i), .rx_lock_i(rx_lock_i),
  .line_monitor_i(line_monitor_i), .patgen_on_i(patgen_on_i),
  .lock_o(lock_o), .pass_o(pass_o), .line_monitor_out_o(line_monitor_out_o),
  .selftest_active_o(selftest_active_o), .out_enable_o(out_enable_o),
  .csi_lp11_o(csi_lp11_o));

// file: dv/sbc_ser_model.sv
// Behavioural remote serializer answering back-channel writes.
`timescale 1ns/1ps
module sbc_ser_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bc_wr_valid_i,
  input wire logic [7:0] bc_wr_addr_i,
  input wire logic [7:0] bc_wr_data_i,
  output logic bc_wr_ready_o,
  input wire logic slow_i,
  input wire logic flip_i,
  input wire logic drop_i,
  output logic [1:0] rx_lock_o,
  output logic [1:0] rx_bit_valid_o,
  output logic [1:0] rx_bit_o,
  output logic [7:0] bc_err_o
);
  logic [1:0] wait_cnt;
  logic [1:0] clk_sel;
  logic [6:0] prbs;
  logic en;
  // Writes are taken at once, or after a three-cycle stall when slow.
  assign bc_wr_ready_o = bc_wr_valid_i && (!slow_i || wait_cnt == 2'h3);
  always_ff @(posedge clk_i) begin
    if (rst_i || bc_wr_ready_o) begin
      wait_cnt <= 2'h0;
    end else if (bc_wr_valid_i) begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
  // Register 0x14 holds the enable and the clock select.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en <= 1'h0;
      clk_sel <= 2'h0;
    end else if (bc_wr_ready_o && bc_wr_addr_i == 8'h14) begin
      en <= bc_wr_data_i[0];
      clk_sel <= bc_wr_data_i[2:1];
    end
  end
  // Frame check: a write outside 0x14 or with reserved bits counts as bad.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bc_err_o <= 8'h00;
    end else if (bc_wr_ready_o && (bc_wr_addr_i != 8'h14 ||
                 bc_wr_data_i[7:3] != 5'h00)) begin
      bc_err_o <= bc_err_o + 8'h01;
    end
  end
  // The sequence runs every cycle, so the link is driven at full rate.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prbs <= 7'h01;
    end else begin
      prbs <= {prbs[5:0], prbs[6] ^ prbs[5]};
    end
  end
  // Port 0 can carry a forced bit error and port 1 a forced lock loss.
  assign rx_lock_o = {en && !drop_i, en};
  assign rx_bit_valid_o = {2{en}};
  assign rx_bit_o = {prbs[0], prbs[0] ^ flip_i};
endmodule : sbc_ser_model

// file: dv/test_sbc_top.sv
// Self-checking bench for the link self-test control.
`timescale 1ns/1ps
module test_sbc_top;
  logic clk_i, rst_i, pin, req_h, req_c, we, lm, patgen, slow, flip, drop;
  logic [1:0] gpio, lock_in, bvalid, bits, lock, pass;
  logic [7:0] addr, wd, h_rd, c_rd, bc_a, bc_d, bc_last, bc_n, lows, bc_err;
  logic h_ack, c_ack, bc_v, bc_rdy, lmo, act, oe, lp11;
  int failures, total_checks;
  sbc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .link_selftest_pin_i(pin),
    .gpio_level_i(gpio), .host_req_i(req_h), .host_we_i(we),
    .host_addr_i(addr), .host_wdata_i(wd), .host_ack_o(h_ack),
    .host_rdata_o(h_rd), .cc_req_i(req_c), .cc_we_i(we), .cc_addr_i(addr),
    .cc_wdata_i(wd), .cc_ack_o(c_ack), .cc_rdata_o(c_rd),
    .bc_wr_valid_o(bc_v), .bc_wr_addr_o(bc_a), .bc_wr_data_o(bc_d),
    .bc_wr_ready_i(bc_rdy), .rx_lock_i(lock_in), .rx_bit_valid_i(bvalid),
    .rx_bit_i(bits), .line_monitor_i(lm), .patgen_on_i(patgen),
    .lock_o(lock), .pass_o(pass), .line_monitor_out_o(lmo),
    .selftest_active_o(act), .out_enable_o(oe), .csi_lp11_o(lp11));
  sbc_ser_model i_ser (.clk_i(clk_i), .rst_i(rst_i), .bc_wr_valid_i(bc_v),
    .bc_wr_addr_i(bc_a), .bc_wr_data_i(bc_d), .bc_wr_ready_o(bc_rdy),
    .slow_i(slow), .flip_i(flip), .drop_i(drop), .rx_lock_o(lock_in),
    .rx_bit_valid_o(bvalid), .rx_bit_o(bits), .bc_err_o(bc_err));
  // Clock of 8 ns and values of every input at time zero.
  initial begin
    {clk_i, pin, req_h, req_c, we, lm, patgen, slow, flip, drop} = 10'h0;
    {rst_i, gpio, addr, wd} = 19'h40000;
    forever #4 clk_i = ~clk_i;
  end
  // Records accepted serializer writes, low pass pulses and toggles lm.
  always @(posedge clk_i) begin
    lm <= ~lm;
    if (rst_i) begin
      {bc_n, bc_last, lows} <= 24'h0;
    end else begin
      if (bc_v && bc_rdy) bc_n <= bc_n + 8'h01;
      if (bc_v && bc_rdy) bc_last <= bc_d;
      if (!pass[0]) lows <= lows + 8'h01;
    end
  end
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic acc(input logic cc, input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] r);
    @(posedge clk_i);
    req_h <= !cc;
    req_c <= cc;
    we <= w;
    addr <= a;
    wd <= d;
    @(posedge clk_i);
    req_h <= 1'h0;
    req_c <= 1'h0;
    #1;
    r = cc ? c_rd : h_rd;
    check("ack", {7'h0, cc ? c_ack : h_ack}, 8'h01);
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    acc(1'h0, 1'h1, a, d, r);
  endtask : wr
  task automatic rchk(input logic cc, input logic [7:0] a,
                      input logic [7:0] e);
    logic [7:0] r;
    acc(cc, 1'h0, a, 8'h00, r);
    check("rdata", r, e);
  endtask : rchk
  task automatic wait_act(input logic v);
    for (int i = 0; i < 20 && act !== v; i++) @(posedge clk_i);
    check("active", {7'h0, act}, {7'h0, v});
  endtask : wait_act
  task automatic results();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  // Cuts a hang short well beyond the expected run of some 2800 cycles.
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    results();
  end
  // Register start, error injection, lock loss, then a pin start.
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    rchk(1'h0, 8'hb3, 8'h00);
    rchk(1'h0, 8'h4c, 8'h03);
    rchk(1'h1, 8'h57, 8'hff);
    rchk(1'h0, 8'h10, 8'h00);
    wr(8'h4c, 8'hff);
    rchk(1'h1, 8'h4c, 8'h33);
    wr(8'h4c, 8'h03);
    slow <= 1'h1;
    wr(8'hb3, 8'h85);
    wait_act(1'h1);
    wr(8'hb3, 8'h83);
    repeat (40) @(posedge clk_i);
    check("bc count", bc_n, 8'h01);
    check("bc data", bc_last, 8'h05);
    check("out enable", {7'h0, oe}, 8'h01);
    check("lp11", {7'h0, lp11}, 8'h01);
    patgen <= 1'h1;
    repeat (3) @(posedge clk_i);
    check("lp11", {7'h0, lp11}, 8'h00);
    for (int i = 0; i < 260; i++) begin
      flip <= 1'h1;
      @(posedge clk_i);
      flip <= 1'h0;
      repeat (9) @(posedge clk_i);
    end
    check("pass pulses", {7'h0, lows != 8'h00}, 8'h01);
    drop <= 1'h1;
    repeat (5) @(posedge clk_i);
    check("lock", {6'h0, lock}, 8'h01);
    check("line monitor", {7'h0, lmo ^ lm}, 8'h01);
    drop <= 1'h0;
    wr(8'hb3, 8'h80);
    wait_act(1'h0);
    check("bc stop", bc_last, 8'h00);
    rchk(1'h0, 8'h57, 8'hfe);
    wr(8'h4c, 8'h13);
    rchk(1'h1, 8'h57, 8'hff);
    wr(8'hb3, 8'h00);
    @(posedge clk_i);
    slow <= 1'h0;
    gpio <= 2'h1;
    pin <= 1'h1;
    wait_act(1'h1);
    repeat (5) @(posedge clk_i);
    gpio <= 2'h0;
    repeat (40) @(posedge clk_i);
    check("bc pin data", bc_last, 8'h03);
    check("bc pin count", bc_n, 8'h03);
    check("out enable", {7'h0, oe}, 8'h00);
    check("pass", {6'h0, pass}, 8'h03);
    rchk(1'h0, 8'h57, 8'h00);
    @(posedge clk_i);
    pin <= 1'h0;
    wait_act(1'h0);
    check("bc pin stop", bc_last, 8'h00);
    check("bc errors", bc_err, 8'h00);
    results();
  end
endmodule : test_sbc_top
